// ==== src/slvd_top.sv ====
// Purpose: control and status logic of the supply low voltage detector
// Assumes: comparator output is asynchronous; sleep and idle come from the core clock domain
// Notes:   APB slave with zero wait states; one level interrupt and one shared request line
`timescale 1ns/10ps
`default_nettype none
module slvd_top
  import slvd_pkg::*;
(
  input  wire logic                    core_clk,           // system clock, 25 MHz
  input  wire logic                    rst,                // synchronous, active high
  // APB slave
  input  wire logic                    psel,               // slave select
  input  wire logic                    penable,            // access phase
  input  wire logic                    pwrite,             // one for write
  input  wire logic [11:0]             paddr,              // byte address
  input  wire logic [31:0]             pwdata,             // write data
  output logic                         pready,             // always ready
  output logic [31:0]                  prdata,             // read data, from flops
  output logic                         pslverr,            // unmapped address
  // analog comparator side
  input  wire logic                    supply_below_trip,  // comparator output, asynchronous
  output logic                         detector_power_en,  // powers the comparator
  output logic [TRIP_LEVEL_W-1:0]      trip_voltage,       // level code to the comparator
  // core side
  input  wire logic                    sleep_mode,         // core in sleep
  input  wire logic                    idle_mode,          // core in idle
  output logic                         monitor_mf_req,     // into shared multi-function interrupt
  output logic                         idle_wake,          // one-cycle wake pulse
  output logic                         irq                 // level interrupt from status and mask
);

  // storage
  // every register of the block; the synchronous reset clears them all
  // the status snapshot exists only so that a read clears what it returned
  // trade-off: a 12-bit delay counter is cheap but caps the request delay
  // at 4095 cycles, so a longer delay needs a wider DELAY_CNT_W
  slvd_ctrl_t             ctrl;              // enable and trip level
  logic                   low_supply_flag;   // registered output flag
  logic                   cmp_sync;          // comparator after two flops
  logic                   monitor_irq_request;  // request flag
  logic                   monitor_irq_enable;   // request enable
  logic [EVT_W-1:0]       int_status;        // sticky events
  logic [EVT_W-1:0]       int_mask;          // event mask
  logic [EVT_W-1:0]       rd_status_snap;    // status value returned by a read
  slvd_dly_t              dly_state;         // request delay machine
  logic [DELAY_CNT_W-1:0] dly_cnt;           // cycles of high flag so far

  // combinational helpers
  // decode and event terms, computed once and shared by the processes
  // below; none of them holds state
  logic                   apb_setup;         // first cycle of a transfer
  logic                   apb_access;        // completing cycle of a transfer
  logic                   wr_en;             // write takes effect now
  logic                   rd_en;             // read completes now
  logic                   addr_hit;          // address maps to a register
  logic                   next_flag;         // next output flag
  logic                   flag_rise;         // output flag goes high
  logic                   flag_fall;         // output flag goes low
  logic                   req_hw_set;        // delay elapsed, set the request
  logic [EVT_W-1:0]       evt_set;           // events of this cycle
  logic [31:0]            next_rdata;        // read mux

  // comparator synchroniser
  // the only crossing of the block: one level, two flops
  // a level needs no gray code or handshake, only a settled copy
  // limitation: a comparator pulse shorter than one clock may be lost,
  // which is harmless because the flag only reports levels
  // the comparator sits in the analog domain, so it is brought onto
  // core_clk before any logic looks at it
  slvd_sync u_cmp_sync (
    .clk      (core_clk),
    .rst      (rst),
    .async_in (supply_below_trip),
    .sync_out (cmp_sync)
  );

  // APB decode
  // zero wait states: the access cycle of every transfer completes it
  // writes act at that edge, reads were captured one edge earlier
  // only the four aligned words decode; a misaligned address is
  // treated like any unmapped one
  assign apb_setup  = psel & ~penable;
  assign apb_access = psel & penable;
  assign pready     = 1'b1;             // zero wait states
  assign wr_en      = apb_access & pwrite & addr_hit;
  assign rd_en      = apb_access & ~pwrite & addr_hit;

  // address match over the four words; anything else is an error
  always_comb begin
    case (paddr)
      SUPPLY_MONITOR_CONTROL_OFS: addr_hit = 1'b1;
      MONITOR_IRQ_CTRL_OFS:       addr_hit = 1'b1;
      INT_STATUS_OFS:             addr_hit = 1'b1;
      INT_MASK_OFS:               addr_hit = 1'b1;
      default:                    addr_hit = 1'b0;
    endcase
  end

  // error only in the access phase, so the master sees it with pready
  assign pslverr = apb_access & ~addr_hit;

  // control register
  // software view of the detector: enable and trip level
  // a level change while enabled may move the flag; software waits again
  // enable and level are the only writable control fields; the flag
  // bit and the unused bits ignore writes
  always_ff @(posedge core_clk) begin
    if (rst) begin
      ctrl <= slvd_ctrl_t'(CONTROL_RESET[TRIP_LEVEL_W:0]);
    end else if (wr_en && paddr == SUPPLY_MONITOR_CONTROL_OFS) begin
      ctrl.monitor_enable    <= pwdata[MONITOR_ENABLE_BIT];
      ctrl.trip_level_select <= slvd_trip_t'(pwdata[TRIP_LEVEL_LSB +: TRIP_LEVEL_W]);
    end
  end

  // sleep overrides the enable bit; the bit itself keeps its value so
  // the detector comes back on after wake-up
  assign detector_power_en = ctrl.monitor_enable & ~sleep_mode;
  assign trip_voltage      = ctrl.trip_level_select;

  // output flag
  // synchronised comparator, gated by the power enable
  // a powered-off detector therefore reads zero
  // hazard: for a few cycles after power-on the flag shows what the
  // comparator gave while it settled; software waits before reading it
  // no debounce: slow supplies near the trip point may toggle the flag
  // many times, and each toggle is shown to software as it happens
  assign next_flag = cmp_sync & detector_power_en;
  assign flag_rise = next_flag & ~low_supply_flag;
  assign flag_fall = ~next_flag & low_supply_flag;

  // registered copy read at bit 5
  always_ff @(posedge core_clk) begin
    if (rst) begin
      low_supply_flag <= 1'b0;
    end else begin
      low_supply_flag <= next_flag;
    end
  end

  // request delay
  // counts core clocks while the flag stays high
  // the request is set once the count reaches MONITOR_IRQ_DELAY_CYC
  // a drop of the flag restarts the count, so a supply that hovers at
  // the trip point sets no request until it stays low long enough
  // the flag must stay high for the whole delay; a drop restarts the
  // wait, and the request is set once per high period
  always_ff @(posedge core_clk) begin
    if (rst) begin
      dly_state <= SLVD_IDLE;
      dly_cnt   <= '0;
    end else begin
      case (dly_state)
        SLVD_IDLE: begin
          dly_cnt <= '0;
          if (low_supply_flag) begin
            dly_state <= SLVD_WAIT;   // flag just went high
            dly_cnt   <= DELAY_CNT_W'(1);
          end
        end
        SLVD_WAIT: begin
          if (!low_supply_flag) begin
            dly_state <= SLVD_IDLE;   // toggle restarts the wait
            dly_cnt   <= '0;
          end else if (dly_cnt >= DELAY_CNT_W'(MONITOR_IRQ_DELAY_CYC)) begin
            dly_state <= SLVD_DONE;
          end else begin
            dly_cnt <= dly_cnt + DELAY_CNT_W'(1);
          end
        end
        SLVD_DONE: begin
          // rearm only after the flag has dropped
          if (!low_supply_flag) begin
            dly_state <= SLVD_IDLE;
          end
          dly_cnt <= '0;
        end
        default: begin
          dly_state <= SLVD_IDLE;
          dly_cnt   <= '0;
        end
      endcase
    end
  end

  // the request is set on the cycle the wait completes
  assign req_hw_set = (dly_state == SLVD_WAIT) & low_supply_flag &
                      (dly_cnt >= DELAY_CNT_W'(MONITOR_IRQ_DELAY_CYC));

  // request flag and enable
  // the flag is the shared request; the enable gates it to the core
  // software may also set the flag, which is how it opts out of a wake
  // hardware only sets the flag; software writes it either way, and a
  // hardware set in the same cycle as a software clear wins
  always_ff @(posedge core_clk) begin
    if (rst) begin
      monitor_irq_request <= 1'b0;
      monitor_irq_enable  <= 1'b0;
    end else begin
      if (wr_en && paddr == MONITOR_IRQ_CTRL_OFS) begin
        monitor_irq_request <= pwdata[IRQ_REQUEST_BIT] | req_hw_set;
        monitor_irq_enable  <= pwdata[IRQ_ENABLE_BIT];
      end else if (req_hw_set) begin
        monitor_irq_request <= 1'b1;
      end
    end
  end

  // shared line into the multi-function interrupt
  assign monitor_mf_req = monitor_irq_request & monitor_irq_enable;

  // idle wake-up
  // a pulse toward the core's power control, registered so it is clean
  // while idle the core clock still runs, so no other domain is involved
  // only a fresh hardware set wakes the core; a flag that software
  // already set before idle masks the hardware set, hence no wake
  always_ff @(posedge core_clk) begin
    if (rst) begin
      idle_wake <= 1'b0;
    end else begin
      idle_wake <= req_hw_set & ~monitor_irq_request & idle_mode;
    end
  end

  // sticky status, mask and interrupt
  // three events feed a status word that a read clears
  // the mask picks which of them raise the level interrupt
  // this is separate from the shared request line, and the two may be
  // used together or alone
  always_comb begin
    evt_set                   = '0;
    evt_set[EVT_LOW_RISE_BIT] = flag_rise;
    evt_set[EVT_LOW_FALL_BIT] = flag_fall;
    evt_set[EVT_REQ_SET_BIT]  = req_hw_set;
  end

  // a read clears only the bits it returned, and a new event in that
  // same cycle stays set
  always_ff @(posedge core_clk) begin
    if (rst) begin
      int_status <= STATUS_RESET;
    end else if (rd_en && paddr == INT_STATUS_OFS) begin
      int_status <= (int_status & ~rd_status_snap) | evt_set;
    end else begin
      int_status <= int_status | evt_set;
    end
  end

  // mask is plain read/write
  always_ff @(posedge core_clk) begin
    if (rst) begin
      int_mask <= MASK_RESET;
    end else if (wr_en && paddr == INT_MASK_OFS) begin
      int_mask <= pwdata[EVT_W-1:0];
    end
  end

  // registered so the output is glitch free
  always_ff @(posedge core_clk) begin
    if (rst) begin
      irq <= 1'b0;
    end else begin
      irq <= |(next_status_view() & int_mask);
    end
  end

  // status as it will be after this edge
  function automatic logic [EVT_W-1:0] next_status_view();
    logic [EVT_W-1:0] v;
    v = int_status | evt_set;
    if (rd_en && paddr == INT_STATUS_OFS) begin
      v = (int_status & ~rd_status_snap) | evt_set;
    end
    return v;
  endfunction : next_status_view

  // read data
  // every word is assembled here and captured at the setup edge
  // a read has no side effect except the status clear on access
  // unused bits of every word read as zero
  always_comb begin
    next_rdata = '0;
    case (paddr)
      SUPPLY_MONITOR_CONTROL_OFS: begin
        next_rdata[LOW_SUPPLY_FLAG_BIT]                 = low_supply_flag;
        next_rdata[MONITOR_ENABLE_BIT]                  = ctrl.monitor_enable;
        next_rdata[TRIP_LEVEL_LSB +: TRIP_LEVEL_W]      = ctrl.trip_level_select;
      end
      MONITOR_IRQ_CTRL_OFS: begin
        next_rdata[IRQ_REQUEST_BIT] = monitor_irq_request;
        next_rdata[IRQ_ENABLE_BIT]  = monitor_irq_enable;
      end
      INT_STATUS_OFS: begin
        next_rdata[EVT_W-1:0] = int_status;
      end
      INT_MASK_OFS: begin
        next_rdata[EVT_W-1:0] = int_mask;
      end
      default: begin
        next_rdata = '0;     // unmapped reads as zero
      end
    endcase
  end

  // captured in the setup cycle so prdata comes from flops and is
  // steady through the access cycle; events landing in between are
  // caught by the snapshot-based clear above
  always_ff @(posedge core_clk) begin
    if (rst) begin
      prdata         <= '0;
      rd_status_snap <= '0;
    end else if (apb_setup && !pwrite) begin
      prdata         <= next_rdata;
      rd_status_snap <= (paddr == INT_STATUS_OFS) ? int_status : '0;
    end
  end

endmodule : slvd_top
`default_nettype wire

// ==== src/slvd_pkg.sv ====
// Purpose: shared constants and types of the supply low voltage detector
// Assumes: 32-bit APB, one word per register, core_clk at 25 MHz
// Notes:   register offsets are byte addresses
package slvd_pkg;

  // clock and timing
  localparam int unsigned CORE_CLK_HZ          = 25_000_000;  // core clock rate
  localparam int unsigned CORE_CLK_PERIOD_NS   = 40;          // one core clock period
  localparam int unsigned MONITOR_IRQ_DELAY_NS = 60_000;      // request delay after low flag rises
  // least time: round up to whole cycles, never below one
  localparam int unsigned MONITOR_IRQ_DELAY_CYC =
    ((MONITOR_IRQ_DELAY_NS + CORE_CLK_PERIOD_NS - 1) / CORE_CLK_PERIOD_NS < 1) ? 1 :
    (MONITOR_IRQ_DELAY_NS + CORE_CLK_PERIOD_NS - 1) / CORE_CLK_PERIOD_NS;
  localparam int unsigned DELAY_CNT_W = 12;                   // wide enough for the delay count

  // register byte offsets
  localparam logic [11:0] SUPPLY_MONITOR_CONTROL_OFS = 12'h000;  // control and output flag
  localparam logic [11:0] MONITOR_IRQ_CTRL_OFS       = 12'h004;  // request flag and its enable
  localparam logic [11:0] INT_STATUS_OFS             = 12'h008;  // sticky events, read clears
  localparam logic [11:0] INT_MASK_OFS               = 12'h00C;  // event mask, same layout

  // control register fields
  localparam int unsigned LOW_SUPPLY_FLAG_BIT  = 5;   // read only output flag
  localparam int unsigned MONITOR_ENABLE_BIT   = 4;   // detector enable
  localparam int unsigned TRIP_LEVEL_LSB       = 0;   // threshold select, bits 2..0
  localparam int unsigned TRIP_LEVEL_W         = 3;
  // request register fields
  localparam int unsigned IRQ_REQUEST_BIT      = 4;   // request flag
  localparam int unsigned IRQ_ENABLE_BIT       = 0;   // request enable
  // status and mask fields
  localparam int unsigned EVT_W                = 3;
  localparam int unsigned EVT_LOW_RISE_BIT     = 0;   // low flag went high
  localparam int unsigned EVT_LOW_FALL_BIT     = 1;   // low flag went low
  localparam int unsigned EVT_REQ_SET_BIT      = 2;   // request flag set by hardware

  // reset values
  localparam logic [7:0]       CONTROL_RESET = 8'h00;
  localparam logic [EVT_W-1:0] STATUS_RESET  = 3'h0;
  localparam logic [EVT_W-1:0] MASK_RESET    = 3'h0;

  // trip levels, encoding of the threshold select field
  typedef enum logic [TRIP_LEVEL_W-1:0] {
    SLVD_TRIP_1V8 = 3'h0, SLVD_TRIP_2V0 = 3'h1, SLVD_TRIP_2V4 = 3'h2, SLVD_TRIP_2V7 = 3'h3,
    SLVD_TRIP_3V0 = 3'h4, SLVD_TRIP_3V3 = 3'h5, SLVD_TRIP_3V6 = 3'h6, SLVD_TRIP_4V0 = 3'h7
  } slvd_trip_t;

  // software held control fields
  typedef struct packed {
    logic       monitor_enable;     // detector on
    slvd_trip_t trip_level_select;  // chosen trip voltage
  } slvd_ctrl_t;

  // request delay state
  typedef enum logic [1:0] {SLVD_IDLE, SLVD_WAIT, SLVD_DONE} slvd_dly_t;

endpackage : slvd_pkg

// ==== src/slvd_sync.sv ====
// Purpose: two flip-flop synchroniser for one level
// Assumes: input is asynchronous to clk
// Notes:   the first stage feeds only the second stage
`timescale 1ns/10ps
`default_nettype none
module slvd_sync (
  input  wire logic clk,       // destination clock
  input  wire logic rst,       // synchronous, active high
  input  wire logic async_in,  // level from another domain
  output var  logic sync_out   // level safe to use on clk
);

  logic meta;  // first stage, read only by sync_out

  // two stages; the first must never fan out to logic
  always_ff @(posedge clk) begin
    if (rst) begin
      meta     <= 1'b0;
      sync_out <= 1'b0;
    end else begin
      meta     <= async_in;
      sync_out <= meta;
    end
  end

endmodule : slvd_sync
`default_nettype wire

// ==== dv/slvd_top_asserts.sv ====
// Purpose: concurrent checks on the detector ports
// Assumes: one clock domain, synchronous active high reset
// Notes:   bound to every slvd_top instance
`timescale 1ns/10ps
`default_nettype none
module slvd_checker
  import slvd_pkg::*;
(
  input wire logic        core_clk,
  input wire logic        rst,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic        pready,
  input wire logic [31:0] prdata,
  input wire logic        pslverr,
  input wire logic        supply_below_trip,
  input wire logic        detector_power_en,
  input wire logic [2:0]  trip_voltage,
  input wire logic        sleep_mode,
  input wire logic        idle_mode,
  input wire logic        monitor_mf_req,
  input wire logic        idle_wake,
  input wire logic        irq
);
  logic [11:0] low_cnt;   // powered cycles the raw comparator has reported low
  logic        ctl_wr;    // control register write taken
  logic        req_wr;    // request register write taken
  logic        ctl_rd;    // control register read in access
  logic [2:0]  wr_level;  // level field of the write data
  logic        wr_enable; // enable bit of the write data
  assign ctl_wr    = psel && penable && pwrite && (paddr == SUPPLY_MONITOR_CONTROL_OFS);
  assign req_wr    = psel && penable && pwrite && (paddr == MONITOR_IRQ_CTRL_OFS);
  assign ctl_rd    = psel && penable && !pwrite && (paddr == SUPPLY_MONITOR_CONTROL_OFS);
  assign wr_level  = pwdata[2:0];
  assign wr_enable = pwdata[MONITOR_ENABLE_BIT];

  // counts from the raw comparator, so it leads the synchronised flag: a safe lower bound
  always_ff @(posedge core_clk) begin
    if (rst || !supply_below_trip || !detector_power_en) begin
      low_cnt <= 12'h000;
    end else if (low_cnt != 12'hFFF) begin
      low_cnt <= low_cnt + 12'h001;
    end
  end

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);

  chk_sleep_power: assert property (sleep_mode |-> !detector_power_en)
    else $error("detector powered while asleep");
  chk_trip_write: assert property (ctl_wr |=> trip_voltage == $past(wr_level))
    else $error("level code not taken from the write");
  chk_trip_hold: assert property (!ctl_wr |=> $stable(trip_voltage))
    else $error("level code moved without a write");
  chk_enable_write: assert property (ctl_wr |=> sleep_mode || detector_power_en == $past(wr_enable))
    else $error("detector power does not follow the enable bit");
  chk_unused_zero: assert property (ctl_rd |-> prdata[31:6] == 26'h0 && !prdata[3])
    else $error("unused control bits read nonzero");
  chk_req_after_delay: assert property ($rose(monitor_mf_req) && !$past(req_wr) |->
    low_cnt >= MONITOR_IRQ_DELAY_CYC) else $error("request set before the delay ran out");
  chk_wake_pulse: assert property (idle_wake |=> !idle_wake)
    else $error("wake pulse longer than one cycle");
  chk_wake_idle: assert property (idle_wake |-> $past(idle_mode))
    else $error("wake pulse outside idle");
  chk_unmapped_err: assert property (psel && penable && paddr > INT_MASK_OFS |-> pslverr)
    else $error("unmapped access without error");

  cover property ($rose(monitor_mf_req));
  cover property ($rose(irq));
  cover property (psel && penable && pslverr);
endmodule : slvd_checker

bind slvd_top slvd_checker u_slvd_checker (
  .core_clk(core_clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
  .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr),
  .supply_below_trip(supply_below_trip), .detector_power_en(detector_power_en),
  .trip_voltage(trip_voltage), .sleep_mode(sleep_mode), .idle_mode(idle_mode),
  .monitor_mf_req(monitor_mf_req), .idle_wake(idle_wake), .irq(irq));
`default_nettype wire

// ==== dv/slvd_supply_model.sv ====
// Purpose: behavioural supply comparator on the far side of the detector
// Assumes: supply given in millivolts by the bench
// Notes:   output is meaningless while unpowered and shows it
`timescale 1ns/10ps
`default_nettype none
module slvd_supply_model
  import slvd_pkg::*;
(
  input  wire logic                    core_clk,          // model steps on the core clock
  input  wire logic                    detector_power_en, // comparator supply
  input  wire logic [TRIP_LEVEL_W-1:0] trip_voltage,      // selected level code
  input  wire logic [15:0]             supply_mv,         // present supply in millivolts
  output var  logic                    supply_below_trip  // high when supply is below trip
);
  // trip voltage of each level code, in millivolts
  function automatic logic [15:0] trip_mv(input logic [2:0] code);
    case (code)
      3'h0: trip_mv = 16'h0708;
      3'h1: trip_mv = 16'h07D0;
      3'h2: trip_mv = 16'h0960;
      3'h3: trip_mv = 16'h0A8C;
      3'h4: trip_mv = 16'h0BB8;
      3'h5: trip_mv = 16'h0CE4;
      3'h6: trip_mv = 16'h0E10;
      default: trip_mv = 16'h0FA0;
    endcase
  endfunction : trip_mv

  // every crossing is passed on; unpowered, a toggling level so nothing may trust it
  always_ff @(posedge core_clk) begin
    if (detector_power_en) begin
      supply_below_trip <= (supply_mv < trip_mv(trip_voltage));
    end else begin
      supply_below_trip <= (supply_below_trip !== 1'b1);
    end
  end
endmodule : slvd_supply_model
`default_nettype wire

// ==== dv/slvd_top_tb.sv ====
// Purpose: self-checking bench of the supply low voltage detector
// Assumes: APB reads checked by a monitor against a queue of expectations
// Notes:   the full request delay is run, 1500 cycles
`timescale 1ns/10ps
`default_nettype none
module slvd_top_tb
  import slvd_pkg::*;
;
  logic        core_clk = 1'b0;  // 25 MHz
  logic        rst, psel, penable, pwrite, pready, pslverr, supply_below_trip;
  logic        detector_power_en, sleep_mode, idle_mode, monitor_mf_req, idle_wake, irq;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, d;
  logic [2:0]  trip_voltage;
  logic [15:0] supply_mv;        // supply seen by the comparator model
  logic [32:0] exp_q[$];         // expected {pslverr, prdata} of each read
  int          fail_count, n_tests, wake_seen, seed, k;

  always #20 core_clk = ~core_clk;

  slvd_top dut (
    .core_clk(core_clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr),
    .supply_below_trip(supply_below_trip), .detector_power_en(detector_power_en),
    .trip_voltage(trip_voltage), .sleep_mode(sleep_mode), .idle_mode(idle_mode),
    .monitor_mf_req(monitor_mf_req), .idle_wake(idle_wake), .irq(irq));

  slvd_supply_model u_supply (
    .core_clk(core_clk), .detector_power_en(detector_power_en), .trip_voltage(trip_voltage),
    .supply_mv(supply_mv), .supply_below_trip(supply_below_trip));

  task automatic check(input string what, input logic [32:0] seen, input logic [32:0] exp);
    n_tests++;
    if (seen !== exp) begin
      fail_count++;
      $display("Error %s expected %0h seen %0h", what, exp, seen);
    end
  endtask : check

  task automatic report_and_stop();
    $display("comparisons %0d mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : report_and_stop

  // one APB transfer; starts on a fresh edge so strobes never change twice in a step
  task automatic apb(input logic write, input logic [11:0] a, input logic [31:0] wd);
    int waits;
    @(posedge core_clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= write;
    paddr <= a;
    pwdata <= wd;
    @(posedge core_clk);
    penable <= 1'b1;
    waits = 0;
    do begin
      @(posedge core_clk);
      waits++;
    end while (pready !== 1'b1 && waits < 16);
    if (pready !== 1'b1) begin
      check("pready", 33'h0, 33'h1);
      report_and_stop();
    end
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic rd(input logic [11:0] a, input logic [32:0] e);
    exp_q.push_back(e);
    apb(1'b0, a, 32'h0);
  endtask : rd

  task automatic step(input int n);
    repeat (n) @(posedge core_clk);
  endtask : step

  // read monitor; also counts wake pulses
  always @(posedge core_clk) begin
    if (psel === 1'b1 && penable === 1'b1 && pready === 1'b1 && pwrite === 1'b0) begin
      if (exp_q.size() != 0) check("read data", {pslverr, prdata}, exp_q.pop_front());
      else check("read queue", 33'h0, 33'h1);
    end
    if (idle_wake === 1'b1) wake_seen++;
  end

  initial begin
    seed = 32'h420C5733;
    {rst, psel, penable, pwrite, paddr, pwdata} = {1'b1, 47'h0};
    {sleep_mode, idle_mode, supply_mv} = {2'h0, 16'h1388};
    step(4);
    rst <= 1'b0;
    check("power_en", {32'h0, detector_power_en}, 33'h0);
    rd(SUPPLY_MONITOR_CONTROL_OFS, 33'h0);
    rd(MONITOR_IRQ_CTRL_OFS, 33'h0);
    rd(INT_STATUS_OFS, 33'h0);
    rd(INT_MASK_OFS, 33'h0);
    $display("reset values done");
    for (k = 0; k < 8; k++) begin
      d = $random(seed);
      d[4] = 1'b1;
      d[2:0] = k[2:0];
      apb(1'b1, SUPPLY_MONITOR_CONTROL_OFS, d);
      step(4);  // settle time after power-on before the flag is read
      check("trip_voltage", {30'h0, trip_voltage}, {30'h0, k[2:0]});
      check("power_en", {32'h0, detector_power_en}, 33'h1);
      rd(SUPPLY_MONITOR_CONTROL_OFS, {30'h0, k[2:0]} | 33'h10);
    end
    $display("level codes done");
    apb(1'b1, SUPPLY_MONITOR_CONTROL_OFS, 32'h13);
    for (k = 0; k < 6; k++) begin
      supply_mv <= k[0] ? 16'h0AF0 : 16'h0A28;
      step(8);
      rd(SUPPLY_MONITOR_CONTROL_OFS, k[0] ? 33'h13 : 33'h33);
    end
    supply_mv <= 16'h09C4;
    sleep_mode <= 1'b1;
    step(8);
    check("power_en", {32'h0, detector_power_en}, 33'h0);
    rd(SUPPLY_MONITOR_CONTROL_OFS, 33'h13);
    sleep_mode <= 1'b0;
    supply_mv <= 16'h1388;
    apb(1'b1, SUPPLY_MONITOR_CONTROL_OFS, 32'h03);
    step(1);
    check("power_en", {32'h0, detector_power_en}, 33'h0);
    apb(1'b1, SUPPLY_MONITOR_CONTROL_OFS, 32'h13);
    step(4);  // power-on settling events land before the status read
    $display("flag and power done");
    rd(INT_STATUS_OFS, 33'h3);
    apb(1'b1, INT_MASK_OFS, 32'h4);
    apb(1'b1, MONITOR_IRQ_CTRL_OFS, 32'h1);
    idle_mode <= 1'b1;
    supply_mv <= 16'h09C4;
    k = 0;
    do begin
      step(1);
      k++;
    end while (monitor_mf_req !== 1'b1 && k < 2000);
    check("request delay", {32'h0, k >= MONITOR_IRQ_DELAY_CYC && k <= MONITOR_IRQ_DELAY_CYC + 12}, 33'h1);
    if (k >= 2000) report_and_stop();
    step(3);
    check("wake count", 33'(wake_seen), 33'h1);
    check("irq", {32'h0, irq}, 33'h1);
    rd(INT_STATUS_OFS, 33'h5);
    supply_mv <= 16'h1388;
    step(8);
    check("irq", {32'h0, irq}, 33'h0);
    rd(MONITOR_IRQ_CTRL_OFS, 33'h11);
    apb(1'b1, MONITOR_IRQ_CTRL_OFS, 32'h10);
    step(1);
    check("mf_req", {32'h0, monitor_mf_req}, 33'h0);
    apb(1'b1, MONITOR_IRQ_CTRL_OFS, 32'h11);
    step(1);
    check("mf_req", {32'h0, monitor_mf_req}, 33'h1);
    $display("request and wake done");
    apb(1'b1, INT_MASK_OFS, 32'h0);
    supply_mv <= 16'h09C4;
    step(1600);
    check("wake count", 33'(wake_seen), 33'h1);
    check("irq", {32'h0, irq}, 33'h0);
    rd(12'h010, {1'b1, 32'h0});
    step(4);
    check("read queue", 33'(exp_q.size()), 33'h0);
    $display("preset and unmapped done");
    report_and_stop();
  end
endmodule : slvd_top_tb
`default_nettype wire
